/* design/dpps_map.vh */
// Constants for the dual-port power state controller.
// Assumes a single 25 MHz clock and synchronous active-high reset.
`ifndef DPPS_MAP_VH
`define DPPS_MAP_VH

// One-hot power state codes
`define DPPS_ST_W 5
`define DPPS_ST_OFF 5'h01
`define DPPS_ST_SLEEP 5'h02
`define DPPS_ST_DETECT 5'h04
`define DPPS_ST_ERROR 5'h08
`define DPPS_ST_ACTIVE 5'h10

// Per-port state codes (one-hot)
`define DPPS_PS_W 4
`define DPPS_PS_OFF 4'h1
`define DPPS_PS_DETECT 4'h2
`define DPPS_PS_ACTIVE 4'h4
`define DPPS_PS_ERROR 4'h8

// Attach qualification time in ns and derived cycle count
`define DPPS_CLK_NS 40
`define DPPS_QUAL_NS 1000
`define DPPS_QUAL_CYC ((`DPPS_QUAL_NS + `DPPS_CLK_NS - 1) / `DPPS_CLK_NS)
`define DPPS_CNT_W 8

`endif

/* design/dpps_ctrl.v */
// Power-state controller for a dual USB port power switch.
// Assumes pin inputs are asynchronous; fault and load inputs come from
// analog comparators and are also synchronised here.
`include "dpps_map.vh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Supply below threshold forces Off, clears all state, bus ignored.
// - Off holds power and bypass switches of both ports open.
// - Sleep is lowest power; logic kept, wakes for bus traffic.
// - Both enables low: Sleep, all switches off, outputs near ground.
// - Detect keeps configuration, no current monitoring, bus fully working.
// - Detect when an enable is on, detection on, nothing attached.
// - Each enabled port goes Active on its own attach conditions.
// - A disabled port beside an enabled one gives only trickle current.
// - Any channel fault gives Error, outranked only by supply loss (Off).
// - Faults latch into separate per-channel interrupt status.
// - A fault affects only its own channel.
// - Active when a channel sources current and no fault; rank two.
// - Active closes power switch, limits current, rations charge.
// - With detection on, switch closed only while attach flag is 1.
// - Detection off and enable on forces Active, switch closed, unless the port faults.
// - Attach when load exceeds threshold longer than qualification time.
// - Enables are ANDed (as disabled) to decide Sleep entry.
module dpps_ctrl (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    // Supply and host pins
    input wire supply_ok,
    input wire port1_power_enable,
    input wire port2_power_enable,
    input wire attach_detect_enable,
    // Analog indications per port
    input wire [1:0] load_over_qual,
    input wire [1:0] fault_in,
    // Software clear of per-channel fault status
    input wire [1:0] fault_status_clear,
    // Switch controls
    output reg [1:0] power_switch_on,
    output reg [1:0] bypass_switch_on,
    output reg [1:0] low_current_mode,
    output reg [1:0] current_limit_en,
    output reg [1:0] charge_ration_en,
    output reg [1:0] discharge_on,
    // Status
    output reg port1_attach_flag,
    output reg port2_attach_flag,
    output reg [1:0] fault_status,
    output reg [`DPPS_ST_W-1:0] power_state,
    output reg bus_respond,
    output reg current_monitor_en
);

////////////////////////////////////////////////////////////////////////////
// Input synchronisers: two flops per pin before any logic reads them
reg sup_meta_reg;
reg sup_sync_reg;
reg [1:0] en_meta_reg;
reg [1:0] en_sync_reg;
reg det_meta_reg;
reg det_sync_reg;
reg [1:0] load_meta_reg;
reg [1:0] load_sync_reg;
reg [1:0] flt_meta_reg;
reg [1:0] flt_sync_reg;

always @(posedge ref_clk) begin
    if (rst) begin
        sup_meta_reg <= 1'b0;
        sup_sync_reg <= 1'b0;
        en_meta_reg <= 2'h0;
        en_sync_reg <= 2'h0;
        det_meta_reg <= 1'b0;
        det_sync_reg <= 1'b0;
        load_meta_reg <= 2'h0;
        load_sync_reg <= 2'h0;
        flt_meta_reg <= 2'h0;
        flt_sync_reg <= 2'h0;
    end else if (clk_en) begin
        sup_meta_reg <= supply_ok;
        sup_sync_reg <= sup_meta_reg;
        en_meta_reg <= {port2_power_enable, port1_power_enable};
        en_sync_reg <= en_meta_reg;
        det_meta_reg <= attach_detect_enable;
        det_sync_reg <= det_meta_reg;
        load_meta_reg <= load_over_qual;
        load_sync_reg <= load_meta_reg;
        flt_meta_reg <= fault_in;
        flt_sync_reg <= flt_meta_reg;
    end
end

// Only the second flop of each pair feeds the control logic
wire sup_s;
wire det_en_s;
wire [1:0] en_s;
wire [1:0] load_s;
wire [1:0] fault_s;
assign sup_s = sup_sync_reg;
assign en_s = en_sync_reg;
assign det_en_s = det_sync_reg;
assign load_s = load_sync_reg;
assign fault_s = flt_sync_reg;

// Sleep only when both enables are low
wire sleep_req;
assign sleep_req = ~en_s[0] & ~en_s[1];

////////////////////////////////////////////////////////////////////////////
// Per-port logic
reg [`DPPS_PS_W-1:0] pst_reg [0:1];
reg [`DPPS_PS_W-1:0] pst_next [0:1];
reg [`DPPS_CNT_W-1:0] qual_reg [0:1];
reg [1:0] att_reg;
reg [1:0] att_next;
reg [1:0] fst_next;
reg [1:0] sw_next;
reg [1:0] byp_next;
reg [1:0] lcm_next;
reg [1:0] lim_next;
reg [1:0] rat_next;
reg [1:0] dis_next;

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
        // Qualify attach: load above threshold for the full time
        always @(posedge ref_clk) begin
            if (rst) begin
                qual_reg[gi] <= {`DPPS_CNT_W{1'b0}};
            end else if (clk_en) begin
                if (!sup_s || !load_s[gi] || !en_s[gi]) begin
                    qual_reg[gi] <= {`DPPS_CNT_W{1'b0}};
                end else if (qual_reg[gi] != `DPPS_QUAL_CYC) begin
                    qual_reg[gi] <= qual_reg[gi] + 1'b1;
                end
            end
        end

        // State resolved fresh every cycle from the inputs
        always @* begin
            att_next[gi] = att_reg[gi];
            if (!sup_s || !en_s[gi] || !load_s[gi]) begin
                att_next[gi] = 1'b0;
            end else if (qual_reg[gi] == `DPPS_QUAL_CYC) begin
                att_next[gi] = 1'b1;
            end
            // Set wins over clear
            fst_next[gi] = (fault_status[gi] & ~fault_status_clear[gi])
                | (sup_s & fault_s[gi]);
            if (!sup_s) begin
                pst_next[gi] = `DPPS_PS_OFF;
                fst_next[gi] = 1'b0;
            end else if (fault_s[gi]) begin
                pst_next[gi] = `DPPS_PS_ERROR;
            end else if (!en_s[gi]) begin
                pst_next[gi] = `DPPS_PS_OFF;
            end else if (!det_en_s) begin
                pst_next[gi] = `DPPS_PS_ACTIVE;
            end else if (att_next[gi]) begin
                pst_next[gi] = `DPPS_PS_ACTIVE;
            end else begin
                pst_next[gi] = `DPPS_PS_DETECT;
            end
        end

        // Switch and mode controls for the resolved port state
        always @* begin
            sw_next[gi] = 1'b0;
            byp_next[gi] = 1'b0;
            lcm_next[gi] = 1'b0;
            lim_next[gi] = 1'b0;
            rat_next[gi] = 1'b0;
            dis_next[gi] = 1'b0;
            case (pst_next[gi])
                `DPPS_PS_ACTIVE: begin
                    sw_next[gi] = 1'b1;
                    lim_next[gi] = 1'b1;
                    rat_next[gi] = 1'b1;
                    // Discharge pulse only on the step out of Detect
                    dis_next[gi] = (pst_reg[gi] == `DPPS_PS_DETECT);
                end
                `DPPS_PS_DETECT: begin
                    byp_next[gi] = 1'b1;
                end
                `DPPS_PS_OFF: begin
                    // Trickle only when the other port is enabled
                    lcm_next[gi] = sup_s & ~sleep_req;
                end
                `DPPS_PS_ERROR: begin
                    // A faulted channel keeps both of its switches open
                    sw_next[gi] = 1'b0;
                    byp_next[gi] = 1'b0;
                end
                default: begin
                    sw_next[gi] = 1'b0;
                end
            endcase
        end

        // Port state, attach and fault status
        always @(posedge ref_clk) begin
            if (rst) begin
                pst_reg[gi] <= `DPPS_PS_OFF;
                att_reg[gi] <= 1'b0;
                fault_status[gi] <= 1'b0;
            end else if (clk_en) begin
                pst_reg[gi] <= pst_next[gi];
                att_reg[gi] <= att_next[gi];
                fault_status[gi] <= fst_next[gi];
            end
        end

        // Switch outputs, registered so each pin comes from a flop
        always @(posedge ref_clk) begin
            if (rst) begin
                power_switch_on[gi] <= 1'b0;
                bypass_switch_on[gi] <= 1'b0;
                low_current_mode[gi] <= 1'b0;
                current_limit_en[gi] <= 1'b0;
                charge_ration_en[gi] <= 1'b0;
                discharge_on[gi] <= 1'b0;
            end else if (clk_en) begin
                power_switch_on[gi] <= sw_next[gi];
                bypass_switch_on[gi] <= byp_next[gi];
                low_current_mode[gi] <= lcm_next[gi];
                current_limit_en[gi] <= lim_next[gi];
                charge_ration_en[gi] <= rat_next[gi];
                discharge_on[gi] <= dis_next[gi];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Device-level state with priority Error > Active > Detect
reg [`DPPS_ST_W-1:0] dst_next;
reg [1:0] any_act;
reg [1:0] any_det;
reg bus_next;
reg mon_next;

always @* begin
    any_act[0] = (pst_next[0] == `DPPS_PS_ACTIVE);
    any_act[1] = (pst_next[1] == `DPPS_PS_ACTIVE);
    any_det[0] = (pst_next[0] == `DPPS_PS_DETECT);
    any_det[1] = (pst_next[1] == `DPPS_PS_DETECT);
    // A fault outranks the enables, so it shows even on a disabled port
    if (!sup_s) begin
        dst_next = `DPPS_ST_OFF;
    end else if (fault_s != 2'h0) begin
        dst_next = `DPPS_ST_ERROR;
    end else if (sleep_req) begin
        dst_next = `DPPS_ST_SLEEP;
    end else if (any_act != 2'h0) begin
        dst_next = `DPPS_ST_ACTIVE;
    end else if (any_det != 2'h0) begin
        dst_next = `DPPS_ST_DETECT;
    end else begin
        dst_next = `DPPS_ST_SLEEP;
    end
end

// Bus answer and current monitoring follow the resolved state
always @* begin
    bus_next = sup_s;
    case (dst_next)
        `DPPS_ST_ACTIVE: mon_next = 1'b1;
        `DPPS_ST_ERROR: mon_next = 1'b1;
        `DPPS_ST_DETECT: mon_next = 1'b0;
        `DPPS_ST_SLEEP: mon_next = 1'b0;
        `DPPS_ST_OFF: mon_next = 1'b0;
        default: mon_next = 1'b0;
    endcase
end

always @(posedge ref_clk) begin
    if (rst) begin
        power_state <= `DPPS_ST_OFF;
        port1_attach_flag <= 1'b0;
        port2_attach_flag <= 1'b0;
    end else if (clk_en) begin
        power_state <= dst_next;
        port1_attach_flag <= att_next[0];
        port2_attach_flag <= att_next[1];
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        bus_respond <= 1'b0;
        current_monitor_en <= 1'b0;
    end else if (clk_en) begin
        bus_respond <= bus_next;
        current_monitor_en <= mon_next;
    end
end

endmodule // dpps_ctrl

/* verification/dpps_chk.sv */
// Assertions on the power state controller ports.
// Assumes checks pause while clk_en is low.
`include "dpps_map.vh"
module dpps_chk (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    // Inputs
    input wire supply_ok,
    input wire port1_power_enable,
    input wire port2_power_enable,
    input wire attach_detect_enable,
    input wire [1:0] load_over_qual,
    input wire [1:0] fault_in,
    // Outputs
    input wire [1:0] power_switch_on,
    input wire [1:0] bypass_switch_on,
    input wire [1:0] low_current_mode,
    input wire port1_attach_flag,
    input wire port2_attach_flag,
    input wire [1:0] fault_status,
    input wire [`DPPS_ST_W-1:0] power_state,
    input wire bus_respond
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || !clk_en);
    wire up = supply_ok;
    wire p1 = port1_power_enable;
    wire p2 = port2_power_enable;
    off_open_a: assert property (power_state == `DPPS_ST_OFF |->
        power_switch_on == 2'h0 && bypass_switch_on == 2'h0) else $error("off");
    no_supply_a: assert property ((!up)[*4] |->
        power_state == `DPPS_ST_OFF && !bus_respond) else $error("supply");
    sleep_and_a: assert property ((!p1 && !p2 && up && fault_in == 2'h0)[*5]
        |-> power_state == `DPPS_ST_SLEEP && power_switch_on == 2'h0
        && bypass_switch_on == 2'h0) else $error("sleep");
    error_prio_a: assert property ((up && fault_in != 2'h0)[*5]
        |-> power_state == `DPPS_ST_ERROR) else $error("error");
    fault_latch_a: assert property ((up && fault_in[1])[*5]
        |-> fault_status[1]) else $error("latch");
    forced_on_a: assert property ((up && p1 && !attach_detect_enable
        && !fault_in[0])[*5] |-> power_switch_on[0]) else $error("forced");
    trickle_a: assert property ((up && p1 && !p2 && fault_in == 2'h0)[*5]
        |-> low_current_mode == 2'h2) else $error("trickle");
    gated_on_a: assert property (attach_detect_enable[*5]
        ##0 power_switch_on[0] |-> port1_attach_flag) else $error("gated");
    attach_qual_a: assert property ($rose(port1_attach_flag)
        |-> $past(load_over_qual[0], 4)) else $error("qual");
    detect_a: assert property ((up && p1 && attach_detect_enable
        && load_over_qual == 2'h0 && fault_in == 2'h0)[*5] ##0
        !port1_attach_flag && !port2_attach_flag
        |-> power_state == `DPPS_ST_DETECT) else $error("detect");
    cover property (power_state == `DPPS_ST_ACTIVE && port1_attach_flag);
    cover property (power_state == `DPPS_ST_ERROR && power_switch_on[0]);
    cover property (power_state == `DPPS_ST_SLEEP);
endmodule // dpps_chk

/* verification/dpps_dev.sv */
// Model of the portable devices attached to both ports.
// Assumes the bench says when a device is plugged or faulty.
module dpps_dev (
    // Clock
    input wire ref_clk,
    // Bench requests
    input wire [1:0] plug,
    input wire [1:0] flt,
    // Analog indications
    output reg [1:0] load_over_qual = 2'h0,
    output reg [1:0] fault_in = 2'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // A plugged device draws above the qualification threshold
    always @(posedge ref_clk) begin
        load_over_qual <= #1 plug;
        fault_in <= #1 flt;
    end
endmodule // dpps_dev

/* verification/tb.sv */
// Self-checking bench for the power state controller.
// Assumes the device model drives load and fault indications.
`include "dpps_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg ref_clk = 0, rst = 1, sup = 1, e1 = 0, e2 = 0, det = 0, ce = 1;
    reg [1:0] plug = 0, flt = 0, clr = 0, on = 0;
    wire [1:0] load, fin, psw, byp, lcm, fst, cle, cre, dis;
    wire a1, a2, bus, cme;
    wire [`DPPS_ST_W-1:0] st;
    integer errors = 0, compares = 0, i;
    dpps_dev i_dpps_dev (.ref_clk(ref_clk), .plug(plug), .flt(flt),
        .load_over_qual(load), .fault_in(fin));
    dpps_ctrl i_dpps_ctrl (.ref_clk(ref_clk), .rst(rst), .clk_en(ce),
        .supply_ok(sup), .port1_power_enable(e1), .port2_power_enable(e2),
        .attach_detect_enable(det), .load_over_qual(load), .fault_in(fin),
        .fault_status_clear(clr), .power_switch_on(psw),
        .bypass_switch_on(byp), .low_current_mode(lcm),
        .current_limit_en(cle), .charge_ration_en(cre), .discharge_on(dis),
        .port1_attach_flag(a1), .port2_attach_flag(a2),
        .fault_status(fst), .power_state(st), .bus_respond(bus),
        .current_monitor_en(cme));
    task chk(input [79:0] nm, input [7:0] ex, input [7:0] got);
        compares = compares + 1;
        if (ex !== got) begin
            errors = errors + 1;
            $display("MISMATCH %0s exp %h got %h", nm, ex, got);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function [4:0] exp_st(input f, input a, input b, input d);
        exp_st = f ? `DPPS_ST_ERROR : !(a | b) ? `DPPS_ST_SLEEP :
            d ? `DPPS_ST_DETECT : `DPPS_ST_ACTIVE;
    endfunction
    task print_verdict;
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // About 310 cycles of tests; allow several times that
    initial begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        void'($urandom(32'h6ce1_2a68));
        cyc(2);
        chk("rst_state", `DPPS_ST_OFF, st);
        rst = 0;
        clr = 2'h3;
        for (i = 0; i < 40; i = i + 1) begin
            {e1, e2, det} = 3'($urandom);
            flt = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
            sup = (i % 9 != 8);
            cyc(6);
            if (!sup) begin
                chk("off_state", `DPPS_ST_OFF, st);
                chk("bus_off", 1'b0, bus);
            end else begin
                chk("state", exp_st(|flt, e1, e2, det), st);
                on = det ? 2'h0 : {e2 & ~flt[1], e1 & ~flt[0]};
                chk("limit", on, cle);
                chk("ration", on, cre);
                chk("bypass_r", det ? {e2, e1} & ~flt : 2'h0, byp);
                chk("monitor", |flt | (~det & (e1 | e2)), cme);
                chk("bus", 1'b1, bus);
                chk("switch", det ? 2'h0 : {e2 & ~flt[1], e1 & ~flt[0]}, psw);
                chk("fault", flt, fst);
                if (flt == 0)
                    chk("trickle", {e1 & ~e2, e2 & ~e1}, lcm);
            end
        end
        {e1, e2, det, flt, clr, sup} = 8'b1010_0001;
        cyc(6);
        chk("bypass", 2'h1, byp);
        plug = 2'h1;
        cyc(20);
        chk("early", 1'b0, a1);
        cyc(9);
        chk("discharge", 2'h1, dis);
        cyc(1);
        chk("dis_end", 2'h0, dis);
        cyc(5);
        chk("attach", 1'b1, a1);
        chk("on", 2'h1, psw);
        chk("active", `DPPS_ST_ACTIVE, st);
        chk("limit_act", 2'h1, cle);
        flt = 2'h2;
        cyc(6);
        chk("err_state", `DPPS_ST_ERROR, st);
        chk("other_on", 2'h1, psw);
        flt = 2'h0;
        cyc(6);
        chk("sticky", 2'h2, fst);
        clr = 2'h2;
        cyc(2);
        chk("cleared", 2'h0, fst);
        ce = 1'b0;
        e1 = 1'b0;
        cyc(6);
        chk("frozen", `DPPS_ST_ACTIVE, st);
        ce = 1'b1;
        cyc(6);
        chk("resumed", `DPPS_ST_SLEEP, st);
        print_verdict;
    end
endmodule // tb
bind dpps_ctrl dpps_chk i_dpps_chk (.ref_clk, .rst, .clk_en, .supply_ok,
    .port1_power_enable, .port2_power_enable, .attach_detect_enable,
    .load_over_qual, .fault_in, .power_switch_on, .bypass_switch_on,
    .low_current_mode, .port1_attach_flag, .port2_attach_flag,
    .fault_status, .power_state, .bus_respond);
